// File: src/increment_skip_execute.v
`timescale 1ns/1ps
`default_nettype none
`include "inc_exec_defs.vh"
module increment_skip_execute #(
  parameter Q_DIV = `Q_DIVIDE
) (
  input wire pclk, // Core clock.
  input wire presetn, // Asynchronous reset, active low.
  input wire psel, // APB select.
  input wire penable, // APB access phase.
  input wire pwrite, // APB direction, high for write.
  input wire [11:0] paddr, // APB byte address.
  input wire [31:0] pwdata, // APB write data.
  output wire pready, // APB ready, always high.
  output reg [31:0] prdata, // APB read data.
  output wire pslverr, // APB error for unmapped addresses.
  input wire instr_valid, // Instruction word offered.
  input wire [15:0] instr_word, // Instruction word.
  input wire instr_two_word, // Offered word starts a two-word instruction.
  output wire instr_ready, // Word taken at this edge.
  input wire [11:0] index_base, // Index pointer for literal offset mode.
  output reg [11:0] file_addr, // File register address.
  input wire [7:0] file_rdata, // File register read data.
  output reg [7:0] file_wdata, // File register write data.
  output reg file_we, // File register write strobe.
  output reg discard_pulse, // Pulses when a prefetched word is dropped.
  output wire [3:0] q_phase // One-hot Q phase, bit 0 is Q1.
);

  localparam ST_IDLE = 3'b001;
  localparam ST_EXEC = 3'b010;
  localparam ST_FLUSH = 3'b100;

  wire tick;
  wire q1_tick;
  wire q2_tick;
  wire q3_tick;
  wire q4_tick;
  wire is_incr;
  wire is_skip;
  wire apb_write;
  wire apb_setup_read;
  wire mapped;
  reg [2:0] state_reg;
  reg [15:0] ir_reg;
  reg [7:0] operand_reg;
  reg [7:0] result_reg;
  reg [4:0] flags_next;
  reg second_word_reg;
  reg last_skip_reg;
  reg ext_enable_reg;
  reg [3:0] bank_select_register;
  reg [7:0] work_reg;
  reg [4:0] status_reg;
  reg [11:0] addr_next;
  reg [31:0] read_mux;

  // Q phase source; one instruction cycle is four phases.
  q_phase_gen #(
    .DIV(Q_DIV)
  ) u_qgen (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .phase_reg(q_phase)
  );

  assign q1_tick = tick & q_phase[0];
  assign q2_tick = tick & q_phase[1];
  assign q3_tick = tick & q_phase[2];
  assign q4_tick = tick & q_phase[3];

  // Opcode decode of the offered word.
  assign is_incr = (instr_word[15:10] == `OPC_INCREMENT);
  assign is_skip = (instr_word[15:10] == `OPC_INC_SKIP);

  // Words are accepted only at the end of Q1, when idle or discarding.
  assign instr_ready = q1_tick & (state_reg[0] | state_reg[2]);

  // Operand address from the bank bit, extended mode and the address field.
  always @* begin
    if (instr_word[`BIT_BANK]) begin
      addr_next = {bank_select_register, instr_word[7:0]};
    end else if (ext_enable_reg && (instr_word[7:0] <= `INDEX_LIMIT)) begin
      addr_next = index_base + {4'h0, instr_word[7:0]};
    end else if (instr_word[7:0] < `ACCESS_SPLIT) begin
      addr_next = {4'h0, instr_word[7:0]};
    end else begin
      addr_next = {`ACCESS_HIGH_BANK, instr_word[7:0]};
    end
  end

  // Flags of the plain increment, computed from the operand.
  always @* begin
    flags_next = status_reg;
    flags_next[`FLAG_CARRY] = (operand_reg == 8'hFF);
    flags_next[`FLAG_NIBBLE] = (operand_reg[3:0] == 4'hF);
    flags_next[`FLAG_ZERO] = (operand_reg == 8'hFF);
    flags_next[`FLAG_OVERFLOW] = (operand_reg == 8'h7F);
    flags_next[`FLAG_NEGATIVE] = (operand_reg[7:0] == 8'h7F) | (operand_reg[7] & (operand_reg != 8'hFF));
  end

  // Instruction sequencer: decode, read, process, write, then any flush cycles.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      ir_reg <= 16'h0000;
      operand_reg <= 8'h00;
      result_reg <= 8'h00;
      file_addr <= 12'h000;
      file_wdata <= 8'h00;
      file_we <= 1'b0;
      discard_pulse <= 1'b0;
      second_word_reg <= 1'b0;
      last_skip_reg <= 1'b0;
    end else begin
      file_we <= 1'b0;
      discard_pulse <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          // Q1: decode; words of other instructions are left alone.
          if (q1_tick && instr_valid && (is_incr || is_skip)) begin
            ir_reg <= instr_word;
            file_addr <= addr_next;
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (q2_tick) begin
            operand_reg <= file_rdata;
          end
          if (q3_tick) begin
            result_reg <= operand_reg + 8'h01;
          end
          if (q4_tick) begin
            file_wdata <= result_reg;
            file_we <= ir_reg[`BIT_DEST];
            if ((ir_reg[15:10] == `OPC_INC_SKIP) && (result_reg == 8'h00)) begin
              state_reg <= ST_FLUSH;
              last_skip_reg <= 1'b1;
            end else begin
              state_reg <= ST_IDLE;
              last_skip_reg <= 1'b0;
            end
          end
        end
        ST_FLUSH: begin
          // Each dropped word costs one no_operation cycle.
          if (q1_tick && instr_valid) begin
            discard_pulse <= 1'b1;
            if (!second_word_reg && instr_two_word) begin
              second_word_reg <= 1'b1;
            end else begin
              second_word_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // APB decode; the slave answers without wait states.
  assign pready = 1'b1;
  assign apb_write = psel & penable & pwrite;
  assign apb_setup_read = psel & ~penable & ~pwrite;
  assign mapped = (paddr == `OFF_CTRL) | (paddr == `OFF_BANK) | (paddr == `OFF_WORK) |
                  (paddr == `OFF_STATUS) | (paddr == `OFF_STATE);
  assign pslverr = psel & penable & ~mapped;

  // Read data selection; unused bits read as zero.
  always @* begin
    case (paddr)
      `OFF_CTRL: read_mux = {31'h00000000, ext_enable_reg};
      `OFF_BANK: read_mux = {28'h0000000, bank_select_register};
      `OFF_WORK: read_mux = {24'h000000, work_reg};
      `OFF_STATUS: read_mux = {27'h0000000, status_reg};
      `OFF_STATE: read_mux = {27'h0000000, second_word_reg, last_skip_reg, state_reg};
      default: read_mux = 32'h00000000;
    endcase
  end

  // Read data is captured in the setup phase and held through access.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (apb_setup_read) begin
      prdata <= read_mux;
    end
  end

  // Control and bank registers are written only by software.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_enable_reg <= `RST_CTRL;
      bank_select_register <= `RST_BANK;
    end else if (apb_write) begin
      if (paddr == `OFF_CTRL) begin
        ext_enable_reg <= pwdata[`CTRL_EXT_BIT];
      end
      if (paddr == `OFF_BANK) begin
        bank_select_register <= pwdata[3:0];
      end
    end
  end

  // Working register and flags: an instruction write wins over software.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work_reg <= `RST_WORK;
      status_reg <= `RST_STATUS;
    end else begin
      if (state_reg[1] && q4_tick && !ir_reg[`BIT_DEST]) begin
        work_reg <= result_reg;
      end else if (apb_write && (paddr == `OFF_WORK)) begin
        work_reg <= pwdata[7:0];
      end
      if (state_reg[1] && q4_tick && (ir_reg[15:10] == `OPC_INCREMENT)) begin
        status_reg <= flags_next;
      end else if (apb_write && (paddr == `OFF_STATUS)) begin
        status_reg <= pwdata[4:0];
      end
    end
  end

endmodule
`default_nettype wire

// File: src/inc_exec_defs.vh
// What this block does
// - Opcode 0010 10da ffff ffff is the plain increment: register plus one.
// - Opcode 0011 11da ffff ffff is increment, skip next instruction when zero.
// - Destination bit 0 writes the working register; 1 writes the file register.
// - Bank bit 0 picks the access bank; 1 lets the bank select register choose.
// - Bank bit 0, extended set on, address up to 95: indexed literal offset.
// - Plain increment updates carry, nibble carry, negative, overflow and zero flags.
// - Skip on zero discards the prefetched instruction, runs a no-operation cycle instead.
// - Increment-and-skip leaves every status flag untouched.
// - Skipping a two-word instruction costs three cycles, one no-operation per word.
`ifndef INC_EXEC_DEFS_VH
`define INC_EXEC_DEFS_VH

// Opcode prefixes in instruction bits 15:10.
`define OPC_INCREMENT 6'h0A
`define OPC_INC_SKIP 6'h0F
// Instruction field positions.
`define BIT_DEST 9
`define BIT_BANK 8

// Access bank split and indexed literal offset limit.
`define ACCESS_SPLIT 8'h60
`define INDEX_LIMIT 8'h5F
`define ACCESS_HIGH_BANK 4'hF

// Status flag positions.
`define FLAG_CARRY 0
`define FLAG_NIBBLE 1
`define FLAG_ZERO 2
`define FLAG_OVERFLOW 3
`define FLAG_NEGATIVE 4

// Register byte offsets.
`define OFF_CTRL 12'h000
`define OFF_BANK 12'h004
`define OFF_WORK 12'h008
`define OFF_STATUS 12'h00C
`define OFF_STATE 12'h010

// Control field and reset values.
`define CTRL_EXT_BIT 0
`define RST_CTRL 1'h0
`define RST_BANK 4'h0
`define RST_WORK 8'h00
`define RST_STATUS 5'h00

// Pclk cycles per Q phase.
`define Q_DIVIDE 1

`endif

// File: src/q_phase_gen.v
`timescale 1ns/1ps
`default_nettype none
module q_phase_gen #(
  parameter DIV = 1
) (
  input wire pclk, // Core clock.
  input wire presetn, // Asynchronous reset, active low.
  output wire tick, // One-cycle enable closing the current Q phase.
  output reg [3:0] phase_reg // One-hot phase, bit 0 is Q1.
);

  reg [7:0] div_reg;

  // Divider produces the phase enable pulse.
  assign tick = (div_reg == (DIV - 1));

  // Divider counts up each cycle and clears on the enable; the phase rotates on the enable.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 8'h00;
      phase_reg <= 4'h1;
    end else begin
      if (tick) begin
        div_reg <= 8'h00;
        phase_reg <= {phase_reg[2:0], phase_reg[3]};
      end else begin
        div_reg <= div_reg + 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

// File: tb/increment_skip_execute_checker.sv
`timescale 1ns/1ps
`default_nettype none
module increment_skip_execute_checker #(
  parameter Q_DIV = 1
) (
  input wire logic pclk, // Core clock.
  input wire logic presetn, // Reset, active low.
  input wire logic instr_valid, // Word offered.
  input wire logic [15:0] instr_word, // Offered word.
  input wire logic instr_ready, // Word taken.
  input wire logic [11:0] file_addr, // Operand address.
  input wire logic [7:0] file_rdata, // Operand value.
  input wire logic [7:0] file_wdata, // Result.
  input wire logic file_we, // Result strobe.
  input wire logic discard_pulse, // Dropped word.
  input wire logic [3:0] q_phase // Phase.
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A taken word that carries one of the two increment opcodes.
  wire take = instr_valid && instr_ready;
  wire inc_op = instr_word[15:10] == 6'h0A || instr_word[15:10] == 6'h0F;
  sequence s_wr;
    take && inc_op && instr_word[9] ##1 !discard_pulse;
  endsequence
  sequence s_wk;
    take && inc_op && !instr_word[9] ##1 !discard_pulse;
  endsequence
  AST_WR: assert property (s_wr |-> ##3 file_we && file_wdata == $past(file_rdata, 3) + 8'h01)
    else $error("file result wrong");
  AST_WK: assert property (s_wk |-> ##3 !file_we)
    else $error("file written for work dest");
  AST_ADDR: assert property (take && inc_op && instr_word[8] ##1 !discard_pulse |->
    file_addr[7:0] == $past(instr_word[7:0]))
    else $error("operand address wrong");
  AST_WEP: assert property (file_we |-> $past(q_phase) == 4'h8 ##1 !file_we)
    else $error("write strobe timing");
  AST_RDY: assert property (instr_ready |-> q_phase == 4'h1)
    else $error("word taken outside Q1");
  AST_HOT: assert property ($onehot(q_phase))
    else $error("phase not one-hot");
  AST_DISC: assert property (discard_pulse |-> $past(take) ##1 !discard_pulse)
    else $error("discard pulse wrong");
  AST_DROP: assert property (take ##1 discard_pulse |-> !file_we [*4])
    else $error("dropped word executed");
endmodule
bind increment_skip_execute increment_skip_execute_checker #(.Q_DIV(Q_DIV)) chk (.pclk, .presetn,
  .instr_valid, .instr_word, .instr_ready, .file_addr, .file_rdata, .file_wdata, .file_we,
  .discard_pulse, .q_phase);
`default_nettype wire

// File: tb/increment_skip_execute_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "inc_exec_defs.vh"
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module increment_skip_execute_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, instr_valid = 0, instr_two_word = 0;
  logic pready, pslverr, instr_ready, file_we, discard_pulse, er, we_seen;
  logic [11:0] paddr = 0, index_base = 0, file_addr, fa;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] instr_word = 0;
  logic [7:0] file_rdata = 0, file_wdata, wd;
  logic [3:0] q_phase;
  int fail_count = 0, n_checks = 0, n_disc = 0;
  increment_skip_execute #(.Q_DIV(1)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .instr_valid, .instr_word, .instr_two_word, .instr_ready,
    .index_base, .file_addr, .file_rdata, .file_wdata, .file_we, .discard_pulse, .q_phase);
  // Clock and a count of dropped words.
  initial forever #10 pclk = ~pclk;
  always @(posedge pclk) if (discard_pulse === 1'b1) n_disc++;
  // One APB transfer; read data and error are taken at the ready edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // Offers a word and holds it until taken.
  task ins(input logic [15:0] w, input logic tw, input logic [7:0] r);
    @(posedge pclk);
    instr_word <= w; instr_two_word <= tw; instr_valid <= 1; file_rdata <= r;
    do @(negedge pclk); while (instr_ready !== 1'b1);
    @(posedge pclk);
    instr_valid <= 0;
  endtask
  // Runs one instruction and records address and any file write.
  task run(input logic [15:0] w, input logic tw, input logic [7:0] r);
    ins(w, tw, r);
    @(negedge pclk) fa = file_addr;
    we_seen = 0;
    repeat (5) begin
      @(negedge pclk);
      if (file_we === 1'b1) begin
        we_seen = 1; wd = file_wdata;
      end
    end
  endtask
  task t_inc;
    apb(1, `OFF_BANK, 32'h2);
    run(16'h2B34, 0, 8'hFF);
    `CHK("addr", 12'h234, fa)
    `CHK("wdata", 9'h100, {we_seen, wd})
    apb(0, `OFF_STATUS, 0);
    `CHK("flags", 32'h07, rd)
    apb(0, 12'h020, 0);
    `CHK("unmapped", 33'h100000000, {er, rd})
  endtask
  task t_work;
    run(16'h2870, 0, 8'h7F);
    `CHK("access hi", 12'hF70, fa)
    `CHK("no write", 1'b0, we_seen)
    apb(0, `OFF_WORK, 0);
    `CHK("work", 32'h80, rd)
    apb(0, `OFF_STATUS, 0);
    `CHK("flags", 32'h1A, rd)
  endtask
  task t_idx;
    run(16'h2810, 0, 8'h00);
    `CHK("access lo", 12'h010, fa)
    apb(1, `OFF_CTRL, 32'h1);
    index_base <= 12'h200;
    run(16'h2810, 0, 8'h00);
    `CHK("indexed", 12'h210, fa)
    run(16'h2860, 0, 8'h00);
    `CHK("above limit", 12'hF60, fa)
    apb(1, `OFF_CTRL, 32'h0);
  endtask
  task t_skip;
    apb(1, `OFF_STATUS, 32'h15);
    n_disc = 0;
    run(16'h3F05, 0, 8'hFF);
    `CHK("skip wdata", 9'h100, {we_seen, wd})
    // Flags are read before the next plain increment rewrites them.
    apb(0, `OFF_STATUS, 0);
    `CHK("flags kept", 32'h15, rd)
    apb(0, `OFF_STATE, 0);
    `CHK("flush state", 32'h0C, rd)
    ins(16'h2B01, 1, 8'h00);
    apb(0, `OFF_STATE, 0);
    `CHK("second word", 32'h1C, rd)
    ins(16'h2B02, 0, 8'h00);
    run(16'h2B05, 0, 8'h41);
    `CHK("after skip", 9'h142, {we_seen, wd})
    `CHK("dropped", 2, n_disc)
    run(16'h3D05, 0, 8'h10);
    run(16'h2B05, 0, 8'h01);
    `CHK("no skip", 9'h102, {we_seen, wd})
    `CHK("none dropped", 2, n_disc)
    apb(0, `OFF_WORK, 0);
    `CHK("skip work", 32'h11, rd)
  endtask
  task stop_test;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence after reset.
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_inc; t_work; t_idx; t_skip;
    stop_test;
  end
  // Watchdog against a hang.
  initial begin
    #200000;
    fail_count++;
    stop_test;
  end
endmodule
`default_nettype wire
